// ### pkg/cfp_consts.svh
`ifndef CFP_CONSTS_SVH
`define CFP_CONSTS_SVH
`define CFP_ADDR_W        32
`define CFP_LINE_BYTES    64
`define CFP_LINE_LSB      6
`define CFP_PAGE_LSB      12
`define CFP_LINE_W        26
`define CFP_AHEAD         2
`define CFP_TRAIN_MISSES  3
`define CFP_TRIGGER_BYTES 512
`define CFP_PF_KIND_W     2
`endif

// ### pkg/cfp_pkg.sv
`include "cfp_consts.svh"
package cfp_pkg;
   typedef struct packed
   {
      logic [`CFP_ADDR_W-1:0] addr;
      logic                   fault;
   } cfp_flush_req_t;
   typedef struct packed
   {
      logic [`CFP_ADDR_W-1:0]    addr;
      logic [`CFP_PF_KIND_W-1:0] kind;
      logic                      present;
   } cfp_swpf_req_t;
   typedef struct packed
   {
      logic [`CFP_ADDR_W-1:0]    addr;
      logic [`CFP_PF_KIND_W-1:0] level;
   } cfp_fill_t;
   typedef enum logic [4:0]
   {
      CFP_IDLE  = 5'h01,
      CFP_WBACK = 5'h02,
      CFP_INVAL = 5'h04,
      CFP_BCAST = 5'h08,
      CFP_DONE  = 5'h10
   } cfp_fstate_t;
endpackage : cfp_pkg

// ### rtl/cfp_top.sv
`timescale 1ns/1ns
`include "cfp_consts.svh"
// Notes on behaviour
// [R1] Flush invalidates the addressed line in all data and instruction cache levels.
// [R2] Each flush invalidation is broadcast to every coherence agent.
// [R3] A dirty copy is written back to memory before invalidation.
// [R4] One flush covers one 64-byte coherency line.
// [R5] Memory type of the page never changes flush behaviour.
// [R6] Flush allowed at any privilege, faults like a one-byte load.
// [R7] Flushes are unordered against other traffic, including flushes.
// [R8] Issuer fences around a flush when ordering matters.
// [R9] Four software prefetch kinds, hints only, no architectural effect.
// [R10] Prefetch of present data may wait or be dropped silently.
// [R11] Hardware prefetcher fills the last-level cache from data miss history.
// [R12] An active stream runs two lines ahead of its position.
// [R13] Constant stride followed only when below half the trigger distance.
// [R14] Non-constant stride triggers when two successive strides are below threshold.
// [R15] Several qualifying misses are needed before any prefetch issues.
// [R16] Streams may run past array ends until they stop.
// [R17] Never crosses a 4-KByte page; retrains on the new page.
// [R18] Trigger distance is a byte parameter.
// [R19] Flush done only after write-back accepted and broadcast sent.
module cfp_top #(
   parameter int unsigned TRIGGER_BYTES = `CFP_TRIGGER_BYTES // [R18]
)(
   input  wire logic                   core_clk_in,
   input  wire logic                   rstn_in,
   input  wire logic                   clk_en_in,
   input  wire logic                   flush_valid_in,
   input  wire cfp_pkg::cfp_flush_req_t flush_req_in,
   output logic                        flush_ready_out,
   output logic                        flush_done_out,
   output logic                        flush_fault_out,
   input  wire logic                   dirty_hit_in,
   output logic                        wback_valid_out,
   output logic [`CFP_ADDR_W-1:0]      wback_addr_out,
   input  wire logic                   wback_accept_in,
   output logic                        inval_valid_out,
   output logic [`CFP_ADDR_W-1:0]      inval_addr_out,
   output logic                        bcast_valid_out,
   input  wire logic                   swpf_valid_in,
   input  wire cfp_pkg::cfp_swpf_req_t swpf_req_in,
   input  wire logic                   mem_busy_in,
   output logic                        swpf_ready_out,
   input  wire logic                   miss_valid_in,
   input  wire logic [`CFP_ADDR_W-1:0] miss_addr_in,
   output logic                        fill_valid_out,
   output cfp_pkg::cfp_fill_t          fill_out,
   output logic                        llc_fill_out,
   input  wire logic                   fill_ready_in
);
   // ***************************************************
   // Line flush
   // ***************************************************
   localparam logic [`CFP_ADDR_W-1:0] LINE_MASK = ~(`CFP_ADDR_W'(`CFP_LINE_BYTES) - `CFP_ADDR_W'(1));
   cfp_pkg::cfp_fstate_t    fstate;
   cfp_pkg::cfp_fstate_t    next_fstate;
   logic [`CFP_ADDR_W-1:0]  faddr;
   logic                    fdirty;
   wire                     take_flush = fstate == cfp_pkg::CFP_IDLE && flush_valid_in;
   // Line-aligned address, memory type deliberately not an input
   wire [`CFP_ADDR_W-1:0]   line_addr = flush_req_in.addr & LINE_MASK; // [R4] [R5]

   always_comb
   begin
      next_fstate = fstate;
      case (fstate)
         cfp_pkg::CFP_IDLE:
            if (flush_valid_in && !flush_req_in.fault)
               next_fstate = dirty_hit_in ? cfp_pkg::CFP_WBACK : cfp_pkg::CFP_INVAL; // [R3]
         cfp_pkg::CFP_WBACK:
            if (wback_accept_in)
               next_fstate = cfp_pkg::CFP_INVAL; // [R19]
         cfp_pkg::CFP_INVAL: next_fstate = cfp_pkg::CFP_BCAST; // [R1]
         cfp_pkg::CFP_BCAST: next_fstate = cfp_pkg::CFP_DONE;  // [R2]
         cfp_pkg::CFP_DONE:  next_fstate = cfp_pkg::CFP_IDLE;
         default:            next_fstate = cfp_pkg::CFP_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         fstate          <= cfp_pkg::CFP_IDLE;
         faddr           <= '0;
         fdirty          <= 1'b0;
         flush_fault_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         fstate          <= next_fstate;
         // Fault reported like a byte load, no cache action taken
         flush_fault_out <= take_flush && flush_req_in.fault; // [R6]
         if (take_flush)
         begin
            faddr  <= line_addr;
            fdirty <= dirty_hit_in;
         end
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         flush_ready_out <= 1'b0;
         flush_done_out  <= 1'b0;
         wback_valid_out <= 1'b0;
         wback_addr_out  <= '0;
         inval_valid_out <= 1'b0;
         inval_addr_out  <= '0;
         bcast_valid_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         // No ordering kept against other traffic; one flush at a time only
         flush_ready_out <= next_fstate == cfp_pkg::CFP_IDLE; // [R7]
         wback_valid_out <= next_fstate == cfp_pkg::CFP_WBACK; // [R3]
         wback_addr_out  <= take_flush ? line_addr : faddr;
         inval_valid_out <= next_fstate == cfp_pkg::CFP_INVAL; // [R1]
         inval_addr_out  <= take_flush ? line_addr : faddr;
         bcast_valid_out <= next_fstate == cfp_pkg::CFP_BCAST; // [R2]
         flush_done_out  <= next_fstate == cfp_pkg::CFP_DONE; // [R19]
      end
   end

   // ***************************************************
   // Software prefetch and hardware stream
   // ***************************************************
   localparam int unsigned TRIG_LINES = TRIGGER_BYTES / `CFP_LINE_BYTES;
   localparam int unsigned HALF_LINES = TRIG_LINES / 2;
   logic [`CFP_LINE_W-1:0] last_line;
   logic [`CFP_LINE_W-1:0] last_stride;
   logic [1:0]             train_cnt;
   logic                   active;
   logic [`CFP_LINE_W-1:0] next_pf;
   logic [`CFP_LINE_W-1:0] head;
   wire [`CFP_LINE_W-1:0] miss_line  = miss_addr_in[`CFP_ADDR_W-1:`CFP_LINE_LSB];
   wire [`CFP_LINE_W-1:0] stride     = miss_line - last_line;
   wire                   same_page  = miss_line[`CFP_LINE_W-1:`CFP_PAGE_LSB-`CFP_LINE_LSB]
                                       == last_line[`CFP_LINE_W-1:`CFP_PAGE_LSB-`CFP_LINE_LSB];
   wire                   fwd        = stride != '0 && stride < `CFP_LINE_W'(TRIG_LINES);
   wire                   const_str  = stride == last_stride;
   // Constant stride must be under half the trigger, varying strides under the full trigger
   wire                   qualify    = same_page && fwd &&
                                       (const_str ? stride < `CFP_LINE_W'(HALF_LINES) : 1'b1); // [R13] [R14]
   wire                   trained    = train_cnt == 2'(`CFP_TRAIN_MISSES - 1); // [R15]
   wire                   pf_same_pg = next_pf[`CFP_LINE_W-1:`CFP_PAGE_LSB-`CFP_LINE_LSB]
                                       == head[`CFP_LINE_W-1:`CFP_PAGE_LSB-`CFP_LINE_LSB];
   // Stream stops at page edge; array ends are not detected
   wire                   hw_want    = active && pf_same_pg &&
                                       next_pf <= head + `CFP_LINE_W'(`CFP_AHEAD); // [R12] [R16] [R17]
   wire                   fill_busy  = fill_valid_out && !fill_ready_in;
   // Every hint waits behind busy memory; present data is then dropped
   wire                   sw_take    = swpf_valid_in && !fill_busy && !mem_busy_in; // [R10]
   wire                   sw_issue   = sw_take && !swpf_req_in.present; // [R9]
   wire                   hw_issue   = hw_want && !fill_busy && !sw_issue;

   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         last_line   <= '0;
         last_stride <= '0;
         train_cnt   <= '0;
         active      <= 1'b0;
         head        <= '0;
         next_pf     <= '0;
      end
      else if (clk_en_in)
      begin
         if (miss_valid_in) // [R11]
         begin
            last_line   <= miss_line;
            last_stride <= stride;
            if (!qualify)
            begin
               train_cnt <= '0; // [R17]
               active    <= 1'b0;
            end
            else if (!trained)
               train_cnt <= train_cnt + 2'h1; // [R15]
            else
            begin
               if (!active)
                  next_pf <= miss_line + 26'h1;
               active <= 1'b1;
               head   <= miss_line;
            end
         end
         else if (hw_issue)
            next_pf <= next_pf + 26'h1;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rstn_in)
      begin
         fill_valid_out <= 1'b0;
         fill_out       <= '0;
         llc_fill_out   <= 1'b0;
         swpf_ready_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         swpf_ready_out <= !fill_busy && !mem_busy_in;
         if (!fill_busy)
         begin
            fill_valid_out <= sw_issue || (hw_issue && !miss_valid_in);
            llc_fill_out   <= !sw_issue;
            if (sw_issue)
               fill_out <= '{addr: swpf_req_in.addr & LINE_MASK, level: swpf_req_in.kind}; // [R9]
            else
               fill_out <= '{addr: {next_pf, 6'h00}, level: 2'h0}; // [R11]
         end
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   property p_wb_first;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $rose(inval_valid_out) && fdirty |-> $past(wback_valid_out);
   endproperty
   a_wb_first: assert property (p_wb_first) else $error("Invalidate without write-back"); // [R3]
   property p_done_after_bcast;
      @(posedge core_clk_in) disable iff (!rstn_in)
      flush_done_out && clk_en_in |-> $past(bcast_valid_out);
   endproperty
   a_done_after_bcast: assert property (p_done_after_bcast) else $error("Done before broadcast"); // [R19]
   property p_bcast_follows;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $rose(inval_valid_out) |-> ##[1:8] bcast_valid_out;
   endproperty
   a_bcast_follows: assert property (p_bcast_follows) else $error("Broadcast missing"); // [R2]
   property p_line_aligned;
      @(posedge core_clk_in) disable iff (!rstn_in)
      inval_valid_out |-> inval_addr_out[5:0] == 6'h00;
   endproperty
   a_line_aligned: assert property (p_line_aligned) else $error("Flush not line aligned"); // [R4]
   property p_fault_no_action;
      @(posedge core_clk_in) disable iff (!rstn_in)
      flush_fault_out |-> !wback_valid_out && !inval_valid_out;
   endproperty
   a_fault_no_action: assert property (p_fault_no_action) else $error("Faulted flush acted"); // [R6]
   property p_ahead;
      @(posedge core_clk_in) disable iff (!rstn_in)
      fill_valid_out && llc_fill_out |-> fill_out.addr[31:6] <= head + 26'h2;
   endproperty
   a_ahead: assert property (p_ahead) else $error("Prefetch too far ahead"); // [R12]
   property p_page;
      @(posedge core_clk_in) disable iff (!rstn_in)
      fill_valid_out && llc_fill_out |-> fill_out.addr[31:12] == head[25:6];
   endproperty
   a_page: assert property (p_page) else $error("Prefetch crossed page"); // [R17]
   property p_train;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $rose(active) |-> $past(trained);
   endproperty
   a_train: assert property (p_train) else $error("Stream started untrained"); // [R15]
   // ***************************************************
   // Further checks on flush and fill sequencing
   // ***************************************************
   // Flush steps are exclusive, so one state drives at most one pulse
   property p_one_step;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $onehot0({wback_valid_out, inval_valid_out, bcast_valid_out, flush_done_out});
   endproperty
   a_one_step: assert property (p_one_step) else $error("Two flush steps at once"); // [R19]
   property p_ready_idle;
      @(posedge core_clk_in) disable iff (!rstn_in)
      flush_ready_out |-> !wback_valid_out && !inval_valid_out && !bcast_valid_out;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("Ready while flush busy"); // [R7]
   property p_wb_aligned;
      @(posedge core_clk_in) disable iff (!rstn_in)
      wback_valid_out |-> wback_addr_out[5:0] == 6'h00;
   endproperty
   a_wb_aligned: assert property (p_wb_aligned) else $error("Write-back not line aligned"); // [R4]
   property p_wb_hold;
      @(posedge core_clk_in) disable iff (!rstn_in)
      wback_valid_out && !wback_accept_in && clk_en_in |=> wback_valid_out;
   endproperty
   a_wb_hold: assert property (p_wb_hold) else $error("Write-back dropped early"); // [R3]
   property p_wb_addr_stable;
      @(posedge core_clk_in) disable iff (!rstn_in)
      wback_valid_out && $past(wback_valid_out) |-> $stable(wback_addr_out);
   endproperty
   a_wb_addr_stable: assert property (p_wb_addr_stable) else $error("Write-back address moved"); // [R3]
   property p_inval_after_accept;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $past(wback_valid_out) && $past(wback_accept_in) && $past(clk_en_in) |-> inval_valid_out;
   endproperty
   a_inval_after_accept: assert property (p_inval_after_accept) else $error("No invalidate after accept"); // [R19]
   property p_bcast_next;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $past(inval_valid_out) && $past(clk_en_in) |-> bcast_valid_out;
   endproperty
   a_bcast_next: assert property (p_bcast_next) else $error("Broadcast late"); // [R2]
   property p_fault_idle;
      @(posedge core_clk_in) disable iff (!rstn_in)
      flush_fault_out |-> flush_ready_out;
   endproperty
   a_fault_idle: assert property (p_fault_idle) else $error("Faulted flush left idle"); // [R6]
   property p_ready_after_done;
      @(posedge core_clk_in) disable iff (!rstn_in)
      flush_done_out && clk_en_in |=> flush_ready_out;
   endproperty
   a_ready_after_done: assert property (p_ready_after_done) else $error("Ready not back after done"); // [R7]
   // A hint never leaves while memory is busy
   property p_sw_not_busy;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $rose(fill_valid_out) && !llc_fill_out |-> !$past(mem_busy_in);
   endproperty
   a_sw_not_busy: assert property (p_sw_not_busy) else $error("Hint issued while busy"); // [R10]
   property p_fill_hold;
      @(posedge core_clk_in) disable iff (!rstn_in)
      fill_valid_out && !fill_ready_in && clk_en_in |=> fill_valid_out && $stable(fill_out);
   endproperty
   a_fill_hold: assert property (p_fill_hold) else $error("Fill changed while stalled"); // [R11]
   property p_llc_level;
      @(posedge core_clk_in) disable iff (!rstn_in)
      fill_valid_out && llc_fill_out |-> fill_out.level == 2'h0;
   endproperty
   a_llc_level: assert property (p_llc_level) else $error("Hardware fill wrong level"); // [R11]
   property p_fill_aligned;
      @(posedge core_clk_in) disable iff (!rstn_in)
      fill_valid_out |-> fill_out.addr[5:0] == 6'h00;
   endproperty
   a_fill_aligned: assert property (p_fill_aligned) else $error("Fill not line aligned"); // [R9]
   property p_active_trained;
      @(posedge core_clk_in) disable iff (!rstn_in)
      active |-> trained;
   endproperty
   a_active_trained: assert property (p_active_trained) else $error("Active without training"); // [R15]
   property p_hw_from_stream;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $rose(fill_valid_out) && llc_fill_out |-> $past(active);
   endproperty
   a_hw_from_stream: assert property (p_hw_from_stream) else $error("Hardware fill without stream"); // [R11]
   // Any break in the pattern, a page change included, drops all training
   property p_retrain;
      @(posedge core_clk_in) disable iff (!rstn_in)
      miss_valid_in && !qualify && clk_en_in |=> !active && train_cnt == 2'h0;
   endproperty
   a_retrain: assert property (p_retrain) else $error("Training kept after break"); // [R17]
   property p_ahead_pos;
      @(posedge core_clk_in) disable iff (!rstn_in)
      active |-> next_pf > head;
   endproperty
   a_ahead_pos: assert property (p_ahead_pos) else $error("Stream behind its head"); // [R12]
endmodule : cfp_top

// ### testbench/cfp_mem_model.sv
`timescale 1ns/1ns
// ************************************************
// Memory side: slow or prompt write-back accept
// ************************************************
// Accept is a one-cycle pulse; fills stall whenever the bench asks
module cfp_mem_model (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       wback_valid_in,
   input  wire logic [3:0] delay_in,
   input  wire logic       stall_in,
   output logic            wback_accept_out,
   output logic            fill_ready_out
);
   logic [3:0] wait_cnt;
   always @(posedge clk_in)
   begin
      wait_cnt         <= #1 (rstn_in && wback_valid_in && !wback_accept_out) ? wait_cnt + 4'h1 : 4'h0;
      wback_accept_out <= #1 rstn_in && wback_valid_in && !wback_accept_out && wait_cnt == delay_in;
      fill_ready_out   <= #1 rstn_in && !stall_in;
   end
endmodule : cfp_mem_model

// ### testbench/cfp_top_tb_top.sv
`timescale 1ns/1ns
`include "cfp_consts.svh"
module cfp_top_tb_top;
   logic core_clk_in, rstn_in, flush_valid_in, dirty_hit_in, wback_accept_in, swpf_valid_in, mem_busy_in;
   logic miss_valid_in, fill_ready_in, flush_ready_out, flush_done_out, flush_fault_out, stall;
   logic wback_valid_out, inval_valid_out, bcast_valid_out, swpf_ready_out, fill_valid_out, llc_fill_out;
   logic [31:0] wback_addr_out, inval_addr_out, miss_addr_in, seed, cycles;
   logic [3:0]  delay;
   logic        clk_en;
   logic [25:0] hw_q[$];
   cfp_pkg::cfp_flush_req_t flush_req_in;
   cfp_pkg::cfp_swpf_req_t  swpf_req_in;
   cfp_pkg::cfp_fill_t      fill_out;
   int bad_count, cmp_count, st;
   // Stalls come and go, so a drained fill never waits for the next random draw
   assign stall = seed[3] & seed[11] & cycles[1];
   cfp_top #(.TRIGGER_BYTES(512)) dut (.clk_en_in(clk_en), .core_clk_in, .rstn_in, .flush_valid_in,
      .flush_req_in, .flush_ready_out, .flush_done_out, .flush_fault_out, .dirty_hit_in, .wback_valid_out,
      .wback_addr_out, .wback_accept_in, .inval_valid_out, .inval_addr_out, .bcast_valid_out, .swpf_valid_in,
      .swpf_req_in, .mem_busy_in, .swpf_ready_out, .miss_valid_in, .miss_addr_in, .fill_valid_out, .fill_out,
      .llc_fill_out, .fill_ready_in);
   cfp_mem_model mem (.clk_in(core_clk_in), .rstn_in, .wback_valid_in(wback_valid_out), .delay_in(delay),
      .stall_in(stall), .wback_accept_out(wback_accept_in), .fill_ready_out(fill_ready_in));
   // ************************************************
   // Clock, watchdog and fill monitor
   // ************************************************
   initial
   begin
      core_clk_in = 0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         report_and_stop();
      end
      if (rstn_in && fill_valid_out === 1'b1 && fill_ready_in && llc_fill_out === 1'b1)
         hw_q.push_back(fill_out.addr[31:6]);
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick
   task automatic do_reset();
      rstn_in = 0;
      tick(8);
      chk("ready_in_reset", 0, flush_ready_out);
      rstn_in = 1;
      tick(1);
      chk("ready_after_reset", 1, flush_ready_out);
   endtask : do_reset
   task automatic flush(input logic [31:0] a, input logic dirty, input logic fault);
      int ci, cb, cd, cw, cf;
      logic [31:0] ia, wa;
      {ci, cb, cd, cw, cf} = {5{-32'sd1}};
      while (flush_ready_out !== 1'b1) tick(1);
      flush_valid_in = 1;
      flush_req_in = '{a, fault};
      dirty_hit_in = dirty;
      delay = 4'(rnd() % 6);
      tick(1);
      flush_valid_in = 0;
      for (int k = 0; k < 20; k++)
      begin
         if (inval_valid_out === 1'b1) {ci, ia} = {k, inval_addr_out};
         if (wback_valid_out === 1'b1) {cw, wa} = {k, wback_addr_out};
         if (bcast_valid_out === 1'b1) cb = k;
         if (flush_done_out === 1'b1) cd = k;
         if (flush_fault_out === 1'b1) cf = k;
         tick(1);
      end
      if (fault)
      begin
         chk("fault_at", 0, cf);
         chk("fault_inval", -1, ci);
         return;
      end
      chk("inval_line", {a[31:6], 6'h00}, ia);
      chk("bcast_at", ci + 1, cb);
      chk("done_at", ci + 2, cd);
      if (dirty)
      begin
         chk("wback_line", {a[31:6], 6'h00}, wa);
         chk("wback_first", 1, cw >= 0 && ci > cw);
      end
      else
         chk("clean_inval_at", 0, ci);
   endtask : flush
   task automatic swpf(input logic [31:0] a, input logic [1:0] kind, input logic pres);
      int got;
      got = 0;
      mem_busy_in = 1;
      swpf_valid_in = 1;
      swpf_req_in = '{a, kind, pres};
      tick(2);
      chk("fill_while_busy", 0, fill_valid_out);
      mem_busy_in = 0;
      // Ready high marks the edge that took the hint; holding on would issue it twice
      while (swpf_ready_out !== 1'b1) tick(1);
      swpf_valid_in = 0;
      for (int k = 0; k < 8 && got == 0; k++)
         if (fill_valid_out === 1'b1) got = 1; else tick(1);
      chk("swpf_fill", !pres, got);
      if (got)
      begin
         chk("fill_level", kind, fill_out.level);
         chk("fill_line", a[31:6], fill_out.addr[31:6]);
         chk("fill_not_llc", 0, llc_fill_out);
      end
      while (fill_valid_out === 1'b1) tick(1);
   endtask : swpf
   task automatic miss(input logic [31:0] a);
      miss_valid_in = 1;
      miss_addr_in = a;
      tick(1);
      miss_valid_in = 0;
      tick(2);
   endtask : miss
   task automatic stream(input logic [5:0] l0, input int s1, input int s2, input int on);
      logic [31:0] b;
      logic [25:0] last;
      int n;
      do_reset();
      hw_q.delete();
      b = {rnd() & 32'hfffff000} | {20'h0, l0, 6'h00};
      // Strides s1, s2, s1: the first miss never qualifies, three more are needed
      miss(b);
      miss(b + s1 * 64);
      miss(b + (s1 + s2) * 64);
      chk("hw_early", 0, hw_q.size());
      last = 26'((b + (2 * s1 + s2) * 64) >> 6);
      miss(b + (2 * s1 + s2) * 64);
      tick(40);
      n = 0;
      foreach (hw_q[i]) n += (hw_q[i] == last + 1 || hw_q[i] == last + 2);
      chk("hw_ahead", on ? 2 - (last[5:0] > 61) - (last[5:0] > 62) : 0, n);
      foreach (hw_q[i]) chk("hw_page", b[31:12], hw_q[i][25:6]);
      if (!on) chk("hw_none", 0, hw_q.size());
   endtask : stream
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   // ************************************************
   // Main sequence
   // ************************************************
   initial
   begin
      {seed, cycles, bad_count, cmp_count} = {32'hca773497, 32'h0, 64'h0};
      {flush_valid_in, dirty_hit_in, swpf_valid_in, mem_busy_in, miss_valid_in, delay} = '0;
      clk_en = 1;
      {flush_req_in, swpf_req_in, miss_addr_in} = '0;
      do_reset();
      $display("test reset done");
      flush(32'hffffffff, 1, 0);
      for (int i = 0; i < 16; i++) flush(rnd(), seed[4], seed[7] & seed[9]);
      $display("test flush done");
      for (int k = 0; k < 4; k++) swpf(rnd(), 2'(k), 1'b0);
      swpf(rnd(), 2'h2, 1'b1);
      $display("test swpf done");
      // Enable low must freeze the flush engine even with a request standing
      clk_en = 0;
      flush_valid_in = 1;
      flush_req_in = '{32'h00000040, 1'b0};
      tick(3);
      chk("frozen_inval", 0, inval_valid_out);
      chk("frozen_ready", 1, flush_ready_out);
      flush_valid_in = 0;
      clk_en = 1;
      $display("test enable done");
      st = 1 + rnd() % 3;
      stream(6'(rnd() % 40), st, st, 1);
      stream(6'h02, 4, 4, 0);
      stream(6'h04, 5, 7, 1);
      stream(6'h04, 3, 8, 0);
      stream(6'h3b, 1, 1, 1);
      $display("test hw prefetch done");
      report_and_stop();
   end
endmodule : cfp_top_tb_top
